// ===== logic/bridge_regs_defs.svh
// Offsets, field positions and reset values of the bridge register block
`ifndef BRIDGE_REGS_DEFS_SVH
`define BRIDGE_REGS_DEFS_SVH
`define UPLIM_HI_OFS   8'h58
`define MASK_GPIO_OFS  8'h64
`define UPLIM_HI_RST   32'h0000_0000
`define MASK_RST       6'h00
`define GPIO_FIELD_RST 4'h0
`define MASK_MSB       6
`define MASK_LSB       1
`define GPIO_CLR_MSB   11
`define GPIO_CLR_LSB   8
`define GPIO_SET_MSB   15
`define GPIO_SET_LSB   12
`define OE_CLR_MSB     19
`define OE_CLR_LSB     16
`define OE_SET_MSB     23
`define OE_SET_LSB     20
`define GPIO_IN_MSB    31
`define GPIO_IN_LSB    28
`define RSVD_LO_BIT    0
`define RSVD_HI_BIT    7
`define RSVD_GPIO_MSB  27
`define RSVD_GPIO_LSB  24
`define LANE_MASK      0
`define LANE_GPIO_DATA 1
`define LANE_GPIO_OE   2
`endif

// ===== logic/bridge_regs_pkg.sv
// Shared types of the bridge register block
`default_nettype none
package bridge_regs_pkg;
	typedef logic [3:0] gpio_vec_type;
	typedef logic [6:1] event_vec_type;
	typedef logic [31:0] word_type;
endpackage : bridge_regs_pkg
`default_nettype wire

// ===== logic/bridge_serr_mask_gpio_regs.sv
// Upper limit word, system error event mask and four-pin GPIO port
`default_nettype none
`include "bridge_regs_defs.svh"

module bridge_serr_mask_gpio_regs (
	input  wire logic                          mclk,         // PCI clock
	input  wire logic                          sys_rst,      // Bridge reset
	input  wire logic                          cfg_wr,       // Config write strobe
	input  wire logic                          cfg_rd,       // Config read strobe
	input  wire logic [7:0]                    cfg_addr,     // Dword byte offset
	input  wire logic [3:0]                    cfg_be,       // Byte enables
	input  wire bridge_regs_pkg::word_type     cfg_wdata,    // Write data
	output logic                               cfg_rvalid,   // Read data valid
	output bridge_regs_pkg::word_type          cfg_rdata,    // Read data
	input  wire bridge_regs_pkg::event_vec_type err_event,   // Error event pulses
	input  wire logic                          serr_enable,  // Command reg enable
	output logic                               primary_system_error_out_n, // Low on error
	output bridge_regs_pkg::word_type          upstream_limit_high, // Limit bits 63:32
	input  wire bridge_regs_pkg::gpio_vec_type gpio_in,      // Pin levels
	output bridge_regs_pkg::gpio_vec_type      gpio_out,     // Pin drive level
	output bridge_regs_pkg::gpio_vec_type      gpio_oe_n     // Low while driving
);

	// Set then clear, so clear wins on a shared bit
	function automatic bridge_regs_pkg::gpio_vec_type apply_w1(
		input bridge_regs_pkg::gpio_vec_type cur,
		input bridge_regs_pkg::gpio_vec_type set_bits,
		input bridge_regs_pkg::gpio_vec_type clr_bits
	);
		apply_w1 = (cur | set_bits) & ~clr_bits;
	endfunction : apply_w1

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction : hit

	bridge_regs_pkg::event_vec_type mask;
	bridge_regs_pkg::gpio_vec_type  clr_last;
	bridge_regs_pkg::gpio_vec_type  set_last;
	bridge_regs_pkg::gpio_vec_type  oe_clr_last;
	bridge_regs_pkg::gpio_vec_type  oe_set_last;
	bridge_regs_pkg::gpio_vec_type  out_data;
	bridge_regs_pkg::gpio_vec_type  out_en;
	bridge_regs_pkg::gpio_vec_type  pin_meta;
	bridge_regs_pkg::gpio_vec_type  pin_sync;
	bridge_regs_pkg::word_type      next_rdata;
	logic                           wr_lim;
	logic                           wr_gpio;
	logic                           fire;

	assign wr_lim  = cfg_wr && hit(cfg_addr, `UPLIM_HI_OFS);
	assign wr_gpio = cfg_wr && hit(cfg_addr, `MASK_GPIO_OFS);

	// Limit upper word, byte-wise
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			upstream_limit_high <= `UPLIM_HI_RST;
		else if (wr_lim)
			for (int b = 0; b < 4; b++)
				if (cfg_be[b])
					upstream_limit_high[b*8 +: 8] <= cfg_wdata[b*8 +: 8];
	end

	// Event mask; bits 0 and 7 are not stored
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			mask <= `MASK_RST;
		else if (wr_gpio && cfg_be[`LANE_MASK])
			mask <= cfg_wdata[`MASK_MSB:`MASK_LSB];
	end

	// Error output, one cycle low per gated event
	assign fire = serr_enable && |(err_event & ~mask);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			primary_system_error_out_n <= 1'b1;
		else
			primary_system_error_out_n <= ~fire;
	end

	// Last written values of the write-one fields
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clr_last <= `GPIO_FIELD_RST;
			set_last <= `GPIO_FIELD_RST;
		end
		else if (wr_gpio && cfg_be[`LANE_GPIO_DATA])
		begin
			clr_last <= cfg_wdata[`GPIO_CLR_MSB:`GPIO_CLR_LSB];
			set_last <= cfg_wdata[`GPIO_SET_MSB:`GPIO_SET_LSB];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			oe_clr_last <= `GPIO_FIELD_RST;
			oe_set_last <= `GPIO_FIELD_RST;
		end
		else if (wr_gpio && cfg_be[`LANE_GPIO_OE])
		begin
			oe_clr_last <= cfg_wdata[`OE_CLR_MSB:`OE_CLR_LSB];
			oe_set_last <= cfg_wdata[`OE_SET_MSB:`OE_SET_LSB];
		end
	end

	// Output data; zero bits leave the level alone
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			out_data <= `GPIO_FIELD_RST;
		else if (wr_gpio && cfg_be[`LANE_GPIO_DATA])
			out_data <= apply_w1(out_data, cfg_wdata[`GPIO_SET_MSB:`GPIO_SET_LSB],
				cfg_wdata[`GPIO_CLR_MSB:`GPIO_CLR_LSB]);
	end

	// Direction; one means the pin is driven as an output
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			out_en <= `GPIO_FIELD_RST;
		else if (wr_gpio && cfg_be[`LANE_GPIO_OE])
			out_en <= apply_w1(out_en, cfg_wdata[`OE_SET_MSB:`OE_SET_LSB],
				cfg_wdata[`OE_CLR_MSB:`OE_CLR_LSB]);
	end

	// Pins follow the registers directly, so a write shows on the same edge that stores it
	assign gpio_out  = out_data;
	assign gpio_oe_n = ~out_en;

	// Pin synchroniser
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_meta <= `GPIO_FIELD_RST;
			pin_sync <= `GPIO_FIELD_RST;
		end
		else
		begin
			pin_meta <= gpio_in;
			pin_sync <= pin_meta;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		next_rdata = '0;
		if (hit(cfg_addr, `UPLIM_HI_OFS))
			next_rdata = upstream_limit_high;
		else if (hit(cfg_addr, `MASK_GPIO_OFS))
		begin
			next_rdata[`MASK_MSB:`MASK_LSB]         = mask;
			next_rdata[`GPIO_CLR_MSB:`GPIO_CLR_LSB] = clr_last;
			next_rdata[`GPIO_SET_MSB:`GPIO_SET_LSB] = set_last;
			next_rdata[`OE_CLR_MSB:`OE_CLR_LSB]     = oe_clr_last;
			next_rdata[`OE_SET_MSB:`OE_SET_LSB]     = oe_set_last;
			next_rdata[`GPIO_IN_MSB:`GPIO_IN_LSB]   = pin_sync;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_rdata  <= '0;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd)
				cfg_rdata <= next_rdata;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_gpio_wr;
		wr_gpio && cfg_be[`LANE_GPIO_DATA];
	endsequence

	sequence s_oe_wr;
		wr_gpio && cfg_be[`LANE_GPIO_OE];
	endsequence

	sequence s_mask_gpio_rd;
		cfg_rd && hit(cfg_addr, `MASK_GPIO_OFS);
	endsequence

	sequence s_unmapped_rd;
		cfg_rd && !hit(cfg_addr, `UPLIM_HI_OFS) && !hit(cfg_addr, `MASK_GPIO_OFS);
	endsequence

	// Mask-only or input-lane writes must leave every pin alone
	sequence s_status_only_wr;
		wr_gpio && !cfg_be[`LANE_GPIO_DATA] && !cfg_be[`LANE_GPIO_OE];
	endsequence

	a_limit_write: assert property (
		wr_lim && cfg_be == 4'hF |=> upstream_limit_high == $past(cfg_wdata))
		else $error("limit word write not stored");

	a_limit_read_path: assert property (
		cfg_rd && hit(cfg_addr, `UPLIM_HI_OFS) |=> cfg_rdata == $past(upstream_limit_high))
		else $error("limit word read path differs");

	// Only the mask and GPIO word has reserved bits; the limit word uses all 32
	a_reserved_zero: assert property (
		s_mask_gpio_rd |=> cfg_rdata[`RSVD_LO_BIT] == 1'b0
			&& cfg_rdata[`RSVD_HI_BIT] == 1'b0
			&& cfg_rdata[`RSVD_GPIO_MSB:`RSVD_GPIO_LSB] == 4'h0)
		else $error("reserved bits read nonzero");

	a_serr_gating: assert property (
		!serr_enable |=> primary_system_error_out_n)
		else $error("system error without enable");

	a_serr_unmasked: assert property (
		serr_enable && |(err_event & ~mask) |=> !primary_system_error_out_n)
		else $error("unmasked event lost");

	a_serr_masked: assert property (
		(err_event & ~mask) == '0 |=> primary_system_error_out_n)
		else $error("masked event raised system error");

	a_set_drives_high: assert property (
		s_gpio_wr |=> (gpio_out & $past(cfg_wdata[`GPIO_SET_MSB:`GPIO_SET_LSB]
			& ~cfg_wdata[`GPIO_CLR_MSB:`GPIO_CLR_LSB])) ==
			$past(cfg_wdata[`GPIO_SET_MSB:`GPIO_SET_LSB]
			& ~cfg_wdata[`GPIO_CLR_MSB:`GPIO_CLR_LSB]))
		else $error("set write did not raise pin");

	a_clear_drives_low: assert property (
		s_gpio_wr |=> (gpio_out & $past(cfg_wdata[`GPIO_CLR_MSB:`GPIO_CLR_LSB])) == 4'h0)
		else $error("clear write did not lower pin");

	a_zero_keeps_data: assert property (
		s_gpio_wr and (cfg_wdata[`GPIO_SET_MSB:`GPIO_CLR_LSB] == 8'h00)
		|=> $stable(gpio_out))
		else $error("zero write changed output");

	a_oe_clear_tristate: assert property (
		s_oe_wr |=> (~gpio_oe_n & $past(cfg_wdata[`OE_CLR_MSB:`OE_CLR_LSB])) == 4'h0)
		else $error("cleared pin still driven");

	a_oe_set_drives: assert property (
		s_oe_wr |=> (gpio_oe_n & $past(cfg_wdata[`OE_SET_MSB:`OE_SET_LSB]
			& ~cfg_wdata[`OE_CLR_MSB:`OE_CLR_LSB])) == 4'h0)
		else $error("set pin not driven");

	a_input_two_flops: assert property (
		$stable(gpio_in)[*3] |-> pin_sync == gpio_in)
		else $error("input field not synced in two cycles");

	a_unmapped_read_zero: assert property (
		s_unmapped_rd |=> cfg_rdata == '0)
		else $error("unmapped offset read nonzero");

	a_status_lane_ignored: assert property (
		s_status_only_wr |=> $stable(gpio_out) && $stable(gpio_oe_n))
		else $error("write without control lanes moved a pin");

	a_oe_zero_keeps: assert property (
		s_oe_wr and (cfg_wdata[`OE_SET_MSB:`OE_CLR_LSB] == 8'h00)
		|=> $stable(gpio_oe_n))
		else $error("zero enable write changed direction");

	a_read_answered: assert property (
		cfg_rd |=> cfg_rvalid)
		else $error("read not answered next cycle");

	// Checked while reset is high, so the default disable is overridden here
	a_reset_values: assert property (@(posedge mclk) disable iff (1'b0)
		sys_rst |=> primary_system_error_out_n && !cfg_rvalid
			&& upstream_limit_high == `UPLIM_HI_RST && gpio_out == `GPIO_FIELD_RST
			&& gpio_oe_n == ~`GPIO_FIELD_RST)
		else $error("outputs not at reset values");

endmodule : bridge_serr_mask_gpio_regs
`default_nettype wire

// ===== tb/gpio_pin_model.sv
// Board-side model of the four GPIO pins
`default_nettype none
module gpio_pin_model (
	input  wire bridge_regs_pkg::gpio_vec_type gpio_out,  // Design drive level
	input  wire bridge_regs_pkg::gpio_vec_type gpio_oe_n, // Low while design drives
	input  wire bridge_regs_pkg::gpio_vec_type ext_level, // Board level when released
	output bridge_regs_pkg::gpio_vec_type      pin_level  // Resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	// A released pin follows the board, a driven one the design
	assign pin_level = (gpio_out & ~gpio_oe_n) | (ext_level & gpio_oe_n);
endmodule : gpio_pin_model
`default_nettype wire

// ===== tb/bridge_serr_mask_gpio_regs_bench.sv
// Self-checking bench for the limit word, event mask and GPIO port
`default_nettype none
module bridge_serr_mask_gpio_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                           mclk;
	logic                           sys_rst;
	logic                           cfg_wr;
	logic                           cfg_rd;
	logic [7:0]                     cfg_addr;
	logic [3:0]                     cfg_be;
	bridge_regs_pkg::word_type      cfg_wdata;
	logic                           cfg_rvalid;
	bridge_regs_pkg::word_type      cfg_rdata;
	bridge_regs_pkg::event_vec_type err_event;
	logic                           serr_enable;
	logic                           serr_n;
	bridge_regs_pkg::word_type      limit;
	bridge_regs_pkg::gpio_vec_type  pins;
	bridge_regs_pkg::gpio_vec_type  gpio_out;
	bridge_regs_pkg::gpio_vec_type  gpio_oe_n;
	bridge_regs_pkg::gpio_vec_type  ext_level;
	int                             error_cnt = 0;
	int                             cmp_count = 0;

	bridge_serr_mask_gpio_regs uut (.mclk(mclk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .err_event(err_event),
		.serr_enable(serr_enable), .primary_system_error_out_n(serr_n),
		.upstream_limit_high(limit), .gpio_in(pins), .gpio_out(gpio_out),
		.gpio_oe_n(gpio_oe_n));
	gpio_pin_model board (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.ext_level(ext_level), .pin_level(pins));

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic final_report;
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge mclk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge mclk);
		cfg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge mclk);
		cfg_rd <= 1'b0;
		#1;
		cmp("rvalid", 32'h1, 32'(cfg_rvalid));
		cmp("rdata", exp, cfg_rdata);
	endtask : rd

	// One event pulse, then the output must be back high a cycle later
	task automatic ev(input int i, input logic exp);
		@(posedge mclk);
		err_event <= 6'h01 << (i - 1);
		@(posedge mclk);
		err_event <= 6'h00;
		#1;
		cmp("serr_n", 32'(exp), 32'(serr_n));
		@(posedge mclk);
		#1;
		cmp("serr_idle", 32'h1, 32'(serr_n));
	endtask : ev

	initial
	begin
		#100000;
		error_cnt++;
		final_report;
	end

	initial
	begin
		sys_rst = 1'b1;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		err_event = 6'h00;
		serr_enable = 1'b1;
		ext_level = 4'h5;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		#1;
		cmp("oe_n", 32'hF, 32'(gpio_oe_n));
		cmp("out", 32'h0, 32'(gpio_out));
		rd(8'h58, 32'h0);
		rd(8'h64, 32'h5000_0000);
		wr(8'h58, 4'hF, 32'hA5A5_5A5A);
		wr(8'h58, 4'h2, 32'hFFFF_FFFF);
		rd(8'h58, 32'hA5A5_FF5A);
		cmp("limit", 32'hA5A5_FF5A, limit);
		wr(8'h60, 4'hF, 32'hFFFF_FFFF);
		rd(8'h60, 32'h0);
		wr(8'h64, 4'h1, 32'hFF);
		rd(8'h64, 32'h5000_007E);
		for (int i = 1; i <= 6; i++) ev(i, 1'b1);
		wr(8'h64, 4'h1, 32'h0);
		for (int i = 1; i <= 6; i++) ev(i, 1'b0);
		@(posedge mclk);
		serr_enable <= 1'b0;
		for (int i = 1; i <= 6; i++) ev(i, 1'b1);
		@(posedge mclk);
		serr_enable <= 1'b1;
		wr(8'h64, 4'h2, 32'h0000_1000);
		cmp("pins", 32'h5, 32'(pins));
		wr(8'h64, 4'h4, 32'h0030_0000);
		cmp("oe_n", 32'hC, 32'(gpio_oe_n));
		cmp("out", 32'h1, 32'(gpio_out));
		wr(8'h64, 4'h2, 32'h0000_1100);
		cmp("out", 32'h0, 32'(gpio_out));
		wr(8'h64, 4'h2, 32'h0000_2000);
		wr(8'h64, 4'h2, 32'h0000_1000);
		cmp("out", 32'h3, 32'(gpio_out));
		wr(8'h64, 4'h2, 32'h0000_0000);
		cmp("out", 32'h3, 32'(gpio_out));
		rd(8'h64, 32'h7030_0000);
		wr(8'h64, 4'h4, 32'h0000_0000);
		cmp("oe_n", 32'hC, 32'(gpio_oe_n));
		wr(8'h64, 4'h2, 32'h0000_0100);
		cmp("out", 32'h2, 32'(gpio_out));
		wr(8'h64, 4'h4, 32'h0001_0000);
		cmp("oe_n", 32'hD, 32'(gpio_oe_n));
		wr(8'h64, 4'h8, 32'hFFFF_FFFF);
		repeat (3) @(posedge mclk);
		rd(8'h64, 32'h7001_0100);
		@(posedge mclk);
		ext_level <= 4'hA;
		repeat (3) @(posedge mclk);
		rd(8'h64, 32'hA001_0100);
		final_report;
	end
endmodule : bridge_serr_mask_gpio_regs_bench
`default_nettype wire
